// file: design/sec_gate_device.sv
/*
 Gauge side: security mode state, key store and a small parameter store.
 Assumes the host presents requests on sec_link_if with one-cycle strobes
 and waits for df_ack before the next parameter request.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module sec_gate_device
  import sec_gate_pkg::*;
(
  input wire logic aclk, // Clock, 100 MHz
  input wire logic aresetn, // Sync reset, low
  sec_link_if.dev link, // Host link
  output sec_gate_pkg::mode_e mode, // Current security level
  output logic boot_start, // Boot entry pulse
  output logic [7:0] neg_delta_volt, // Negative delta volt, mV
  output logic [15:0] inhibit_temp_low, // Inhibit temp low, 0.1 C
  output logic [7:0] taper_window // Taper window, s
);
  import sec_gate_pkg::*;

  // ****************************************
  // Key pair detection
  // ****************************************
  logic [15:0] unseal_k0_reg, unseal_k1_reg, full_k0_reg, full_k1_reg;
  logic [15:0] unseal_k0_next, unseal_k1_next, full_k0_next, full_k1_next;
  logic unseal_hit;
  logic full_hit;

  // Keys arrive byte swapped relative to stored words
  key_pair_matcher u_unseal_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd_valid(link.cmd_valid),
    .cmd_word(link.cmd_word),
    .key_first({unseal_k0_reg[7:0], unseal_k0_reg[15:8]}),
    .key_second({unseal_k1_reg[7:0], unseal_k1_reg[15:8]}),
    .match(unseal_hit)
  );

  key_pair_matcher u_full_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd_valid(link.cmd_valid),
    .cmd_word(link.cmd_word),
    .key_first({full_k0_reg[7:0], full_k0_reg[15:8]}),
    .key_second({full_k1_reg[7:0], full_k1_reg[15:8]}),
    .match(full_hit)
  );

  // ****************************************
  // Security mode
  // ****************************************
  mode_e mode_reg;
  mode_e mode_next;
  logic boot_reg;
  logic boot_next;
  logic ss_reg;
  logic ss_next;
  logic full_flag_reg;
  logic full_flag_next;

  always_comb begin
    mode_next = mode_reg;
    boot_next = 1'b0;
    case (mode_reg)
      MODE_SEALED: begin
        if (unseal_hit) begin
          mode_next = MODE_UNSEALED;
        end
      end
      MODE_UNSEALED: begin
        if (full_hit) begin
          mode_next = MODE_FULL;
        end
      end
      MODE_FULL: begin
        if (link.cmd_valid && link.cmd_word == SUBCMD_BOOT) begin
          boot_next = 1'b1;
        end
      end
      default: begin
        mode_next = MODE_SEALED;
      end
    endcase
    // Sealing is a plain subcommand, allowed from any level
    if (link.cmd_valid && link.cmd_word == SUBCMD_SEAL) begin
      mode_next = MODE_SEALED;
    end
    ss_next = (mode_next == MODE_SEALED);
    full_flag_next = (mode_next != MODE_FULL);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_SEALED;
      boot_reg <= 1'b0;
      ss_reg <= 1'b1;
      full_flag_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      boot_reg <= boot_next;
      ss_reg <= ss_next;
      full_flag_reg <= full_flag_next;
    end
  end

  // ****************************************
  // Parameter and key store
  // ****************************************
  logic [7:0] neg_delta_reg, neg_delta_next;
  logic [15:0] inhibit_low_reg, inhibit_low_next;
  logic [7:0] taper_reg, taper_next;
  logic [15:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic wr_ok;
  logic key_ok;

  always_comb begin
    neg_delta_next = neg_delta_reg;
    inhibit_low_next = inhibit_low_reg;
    taper_next = taper_reg;
    unseal_k0_next = unseal_k0_reg;
    unseal_k1_next = unseal_k1_reg;
    full_k0_next = full_k0_reg;
    full_k1_next = full_k1_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    // Sealed store is read only; key word writes need full access
    wr_ok = link.df_we && (mode_reg != MODE_SEALED);
    key_ok = (mode_reg == MODE_FULL);
    if (link.df_req) begin
      ack_next = 1'b1;
      case (link.df_addr)
        ADDR_NEG_DELTA: begin
          rdata_next = {8'h00, neg_delta_reg};
          if (wr_ok && link.df_wdata[15:8] == 8'h00 && link.df_wdata[7:0] <= NEG_DELTA_MAX) begin
            neg_delta_next = link.df_wdata[7:0];
          end else if (link.df_we) begin
            err_next = 1'b1;
          end
        end
        ADDR_INHIBIT_LOW: begin
          rdata_next = inhibit_low_reg;
          if (wr_ok && $signed(link.df_wdata) >= INHIBIT_LOW_MIN
              && $signed(link.df_wdata) <= INHIBIT_LOW_MAX) begin
            inhibit_low_next = link.df_wdata;
          end else if (link.df_we) begin
            err_next = 1'b1;
          end
        end
        ADDR_TAPER_WIN: begin
          rdata_next = {8'h00, taper_reg};
          if (wr_ok && link.df_wdata[15:8] == 8'h00 && link.df_wdata[7:0] <= TAPER_WIN_MAX) begin
            taper_next = link.df_wdata[7:0];
          end else if (link.df_we) begin
            err_next = 1'b1;
          end
        end
        ADDR_UNSEAL_K0, ADDR_UNSEAL_K1, ADDR_FULL_K0, ADDR_FULL_K1: begin
          if (mode_reg == MODE_SEALED || (link.df_we && !key_ok)) begin
            err_next = 1'b1;
          end else begin
            case (link.df_addr)
              ADDR_UNSEAL_K0: rdata_next = unseal_k0_reg;
              ADDR_UNSEAL_K1: rdata_next = unseal_k1_reg;
              ADDR_FULL_K0: rdata_next = full_k0_reg;
              default: rdata_next = full_k1_reg;
            endcase
            if (link.df_we) begin
              case (link.df_addr)
                ADDR_UNSEAL_K0: unseal_k0_next = link.df_wdata;
                ADDR_UNSEAL_K1: unseal_k1_next = link.df_wdata;
                ADDR_FULL_K0: full_k0_next = link.df_wdata;
                default: full_k1_next = link.df_wdata;
              endcase
            end
          end
        end
        default: begin
          rdata_next = 16'h0000;
          err_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      neg_delta_reg <= NEG_DELTA_RST;
      inhibit_low_reg <= INHIBIT_LOW_RST;
      taper_reg <= TAPER_WIN_RST;
      unseal_k0_reg <= UNSEAL_K0_RST;
      unseal_k1_reg <= UNSEAL_K1_RST;
      full_k0_reg <= FULL_K0_RST;
      full_k1_reg <= FULL_K1_RST;
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      neg_delta_reg <= neg_delta_next;
      inhibit_low_reg <= inhibit_low_next;
      taper_reg <= taper_next;
      unseal_k0_reg <= unseal_k0_next;
      unseal_k1_reg <= unseal_k1_next;
      full_k0_reg <= full_k0_next;
      full_k1_reg <= full_k1_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  assign link.df_ack = ack_reg;
  assign link.df_err = err_reg;
  assign link.df_rdata = rdata_reg;
  assign link.sealed_flag = ss_reg;
  assign link.full_access_state_flag = full_flag_reg;
  assign mode = mode_reg;
  assign boot_start = boot_reg;
  assign neg_delta_volt = neg_delta_reg;
  assign inhibit_temp_low = inhibit_low_reg;
  assign taper_window = taper_reg;
endmodule : sec_gate_device

// file: design/sec_gate_pkg.sv
/*
 Constants, types and addresses shared by both ends of the security key
 gate and its parameter store. Assumes a single 100 MHz clock domain.
*/
// Contract
// - Three levels; change only on correct keys (code also drops to sealed on SUBCMD_SEAL from any level)
// - Each transition has its own key pair
// - Keys back to back, no write between
// - Host keys never equal a subcommand code
// - Sealed flag set while sealed, cleared on unseal
// - Full access flag cleared on full keys
// - Each key held as two 16-bit words
// - Key words writable only in full access
// - Host swaps key bytes when presenting them
// - Negative delta volt byte, 36/23, default 17
// - Inhibit temp low, 32/0, signed, -400..1200
// - Taper window byte, max 60, default 40
// - Only full access writes keys or boots
package sec_gate_pkg;
  typedef enum logic [1:0] {
    MODE_SEALED = 2'b00,
    MODE_UNSEALED = 2'b01,
    MODE_FULL = 2'b10
  } mode_e;
  // Parameter store addresses: {subclass, offset}
  localparam logic [15:0] ADDR_NEG_DELTA = {8'd36, 8'd23};
  localparam logic [15:0] ADDR_INHIBIT_LOW = {8'd32, 8'd0};
  localparam logic [15:0] ADDR_TAPER_WIN = {8'd36, 8'd6};
  localparam logic [15:0] ADDR_UNSEAL_K0 = {8'd112, 8'd0};
  localparam logic [15:0] ADDR_UNSEAL_K1 = {8'd112, 8'd2};
  localparam logic [15:0] ADDR_FULL_K0 = {8'd112, 8'd4};
  localparam logic [15:0] ADDR_FULL_K1 = {8'd112, 8'd6};
  // Stored defaults and limits
  localparam logic [7:0] NEG_DELTA_RST = 8'd17;
  localparam logic [7:0] NEG_DELTA_MAX = 8'd100;
  localparam logic signed [15:0] INHIBIT_LOW_RST = 16'sd0;
  localparam logic signed [15:0] INHIBIT_LOW_MIN = -16'sd400;
  localparam logic signed [15:0] INHIBIT_LOW_MAX = 16'sd1200;
  localparam logic [7:0] TAPER_WIN_RST = 8'd40;
  localparam logic [7:0] TAPER_WIN_MAX = 8'd60;
  // Key defaults are arbitrary values
  localparam logic [15:0] UNSEAL_K0_RST = 16'h1A2B;
  localparam logic [15:0] UNSEAL_K1_RST = 16'h3C4D;
  localparam logic [15:0] FULL_K0_RST = 16'h5E6F;
  localparam logic [15:0] FULL_K1_RST = 16'h7A8B;
  // Control subcommand codes
  localparam logic [15:0] SUBCMD_SEAL = 16'h0020;
  localparam logic [15:0] SUBCMD_BOOT = 16'h0F00;
  // Host register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_DF_ADDR = 8'h08;
  localparam logic [7:0] OFS_DF_WDATA = 8'h0C;
  localparam logic [7:0] OFS_DF_CTRL = 8'h10;
  localparam logic [7:0] OFS_DF_RDATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_MODE = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : sec_gate_pkg

// file: design/sec_link_if.sv
/*
 Link between host controller and gauge security gate.
 Assumes both ends share aclk; no crossing is needed.
*/
`timescale 1ns/10ps
interface sec_link_if;
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic df_req;
  logic df_we;
  logic [15:0] df_addr;
  logic [15:0] df_wdata;
  logic df_ack;
  logic df_err;
  logic [15:0] df_rdata;
  logic sealed_flag;
  logic full_access_state_flag;
  modport dev (
    input cmd_valid, cmd_word, df_req, df_we, df_addr, df_wdata,
    output df_ack, df_err, df_rdata, sealed_flag, full_access_state_flag
  );
  modport host (
    output cmd_valid, cmd_word, df_req, df_we, df_addr, df_wdata,
    input df_ack, df_err, df_rdata, sealed_flag, full_access_state_flag
  );
endinterface : sec_link_if

// file: design/key_pair_matcher.sv
/*
 Detects one two-word key pair among control command writes.
 Assumes command writes arrive as one-cycle strobes on aclk.
*/
`timescale 1ns/10ps
module key_pair_matcher (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic cmd_valid, // Command word strobe
  input wire logic [15:0] cmd_word, // Command word
  input wire logic [15:0] key_first, // Expected first word
  input wire logic [15:0] key_second, // Expected second word
  output logic match // Pair seen, one cycle
);
  logic armed_reg;
  logic armed_next;
  logic match_reg;
  logic match_next;

  always_comb begin
    armed_next = armed_reg;
    match_next = 1'b0;
    if (cmd_valid) begin
      if (armed_reg) begin
        // Any second word ends the attempt; a miss does not rearm
        match_next = (cmd_word == key_second);
        armed_next = 1'b0;
      end else begin
        armed_next = (cmd_word == key_first);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      match_reg <= match_next;
    end
  end

  assign match = match_reg;
endmodule : key_pair_matcher

// file: design/sec_gate_host.sv
/*
 Host controller: AXI4-Lite register slave that sends command words and
 parameter requests over sec_link_if. Assumes software keeps key words
 back to back and never uses a subcommand code as a key.
*/
`timescale 1ns/10ps
module sec_gate_host
  import sec_gate_pkg::*;
(
  input wire logic aclk, // Clock, 100 MHz
  input wire logic aresetn, // Sync reset, low
  sec_link_if.host link, // Device link
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [7:0] awaddr, // Write address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [7:0] araddr, // Read address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic irq // Level interrupt
);
  import sec_gate_pkg::*;

  // ****************************************
  // Bus slave and control registers
  // ****************************************
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] aw_reg, aw_next;
  logic [31:0] w_reg, w_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic cmd_v_reg, cmd_v_next, req_reg, req_next, we_reg, we_next, busy_reg, busy_next;
  logic [15:0] cmd_reg, cmd_next, addr_reg, addr_next, wd_reg, wd_next, rd_reg, rd_next;
  logic [2:0] stat_reg, stat_next, mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic awready_reg, wready_reg, arready_reg;
  logic [1:0] flags_reg;
  logic do_wr;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_next = aw_reg;
    w_next = w_reg;
    bvalid_next = bvalid_reg && !bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    cmd_v_next = 1'b0;
    cmd_next = cmd_reg;
    req_next = 1'b0;
    we_next = we_reg;
    busy_next = busy_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      aw_next = awaddr;
    end
    if (wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      w_next = wdata;
    end
    do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
    if (do_wr) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (aw_reg)
        OFS_CMD: begin
          cmd_v_next = 1'b1;
          cmd_next = w_reg[15:0];
        end
        OFS_KEY: begin
          cmd_v_next = 1'b1;
          cmd_next = {w_reg[7:0], w_reg[15:8]};
        end
        OFS_DF_ADDR: addr_next = w_reg[15:0];
        OFS_DF_WDATA: wd_next = w_reg[15:0];
        OFS_DF_CTRL: begin
          // Ignored while a request is outstanding
          if (!busy_reg && (w_reg[0] || w_reg[1])) begin
            req_next = 1'b1;
            we_next = w_reg[0];
            busy_next = 1'b1;
          end
        end
        OFS_IRQ_STAT: stat_next = stat_reg & ~w_reg[2:0];
        OFS_IRQ_MASK: mask_next = w_reg[2:0];
        OFS_DF_RDATA, OFS_STATUS: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (araddr)
        OFS_DF_ADDR: rdata_next = {16'h0000, addr_reg};
        OFS_DF_WDATA: rdata_next = {16'h0000, wd_reg};
        OFS_DF_RDATA: rdata_next = {16'h0000, rd_reg};
        OFS_STATUS: rdata_next = {29'h00000000, busy_reg, flags_reg};
        OFS_IRQ_STAT: rdata_next = {29'h00000000, stat_reg};
        OFS_IRQ_MASK: rdata_next = {29'h00000000, mask_reg};
        OFS_CMD, OFS_KEY, OFS_DF_CTRL: rdata_next = 32'h00000000;
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    // Events set after the clear so a same-cycle event survives
    if (link.df_ack) begin
      busy_next = 1'b0;
      rd_next = link.df_rdata;
      stat_next[IRQ_DONE] = 1'b1;
      stat_next[IRQ_ERR] = stat_next[IRQ_ERR] | link.df_err;
    end
    if ({link.sealed_flag, link.full_access_state_flag} != flags_reg) begin
      stat_next[IRQ_MODE] = 1'b1;
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_reg <= 8'h00;
      w_reg <= 32'h00000000;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
      cmd_v_reg <= 1'b0;
      cmd_reg <= 16'h0000;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      busy_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wd_reg <= 16'h0000;
      rd_reg <= 16'h0000;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      irq_reg <= 1'b0;
      flags_reg <= 2'h3;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      cmd_v_reg <= cmd_v_next;
      cmd_reg <= cmd_next;
      req_reg <= req_next;
      we_reg <= we_next;
      busy_reg <= busy_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      flags_reg <= {link.sealed_flag, link.full_access_state_flag};
      awready_reg <= !aw_have_next;
      wready_reg <= !w_have_next;
      arready_reg <= !rvalid_next;
    end
  end

  // Ready outputs are own flops: high while the holding slot is empty
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign arready = arready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq = irq_reg;
  assign link.cmd_valid = cmd_v_reg;
  assign link.cmd_word = cmd_reg;
  assign link.df_req = req_reg;
  assign link.df_we = we_reg;
  assign link.df_addr = addr_reg;
  assign link.df_wdata = wd_reg;
endmodule : sec_gate_host

// file: testbench/sec_gate_assertions.sv
/*
 Checker on the link between gate host and gauge device.
 Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/10ps
module sec_gate_assertions
  import sec_gate_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic cmd_valid, // Command strobe
  input wire logic df_req, // Param request
  input wire logic df_we, // Param write
  input wire logic [15:0] df_addr, // Param address
  input wire logic [15:0] df_wdata, // Param data
  input wire logic df_ack, // Param answer
  input wire logic df_err, // Param refused
  input wire logic sealed_flag, // Sealed level
  input wire logic full_access_state_flag // Low in full access
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_req;
  logic [15:0] tmax;
  assign wr_req = df_req && df_we;
  assign tmax = {8'h00, TAPER_WIN_MAX};
  ack_one_a: assert property (df_req |=> df_ack ##1 !df_ack)
    else $error("df_ack not one cycle after df_req");
  err_ack_a: assert property (df_err |-> df_ack)
    else $error("df_err without df_ack");
  sealed_wr_a: assert property (wr_req && sealed_flag |=> df_err)
    else $error("write accepted while sealed");
  key_wr_a: assert property (wr_req && df_addr[15:8] == ADDR_UNSEAL_K0[15:8]
    && full_access_state_flag |=> df_err) else $error("key write outside full");
  taper_rng_a: assert property (wr_req && df_addr == ADDR_TAPER_WIN
    && df_wdata > tmax |=> df_err) else $error("taper over range taken");
  taper_ok_a: assert property (wr_req && !full_access_state_flag
    && df_addr == ADDR_TAPER_WIN && df_wdata <= tmax |=> !df_err)
    else $error("taper in range refused");
  neg_rng_a: assert property (wr_req && df_addr == ADDR_NEG_DELTA
    && df_wdata > {8'h00, NEG_DELTA_MAX} |=> df_err) else $error("neg over range taken");
  inh_rng_a: assert property (wr_req && df_addr == ADDR_INHIBIT_LOW
    && ($signed(df_wdata) < INHIBIT_LOW_MIN || $signed(df_wdata) > INHIBIT_LOW_MAX)
    |=> df_err) else $error("inhibit out of range taken");
  level_excl_a: assert property (!(sealed_flag && !full_access_state_flag))
    else $error("sealed and full together");
  seal_chg_a: assert property ($changed(sealed_flag) |-> $past(cmd_valid)
    || $past(cmd_valid, 2) || $past(cmd_valid, 3)) else $error("sealed moved alone");
  fas_chg_a: assert property ($changed(full_access_state_flag) |-> $past(cmd_valid)
    || $past(cmd_valid, 2) || $past(cmd_valid, 3)) else $error("full flag moved alone");
endmodule : sec_gate_assertions

// file: testbench/test_security_key_unlock_and_param_store.sv
/*
 Bench: AXI4-Lite master drives the gate host joined to the gauge device.
 Assumes the package, interface and both ends compile first.
*/
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module test_security_key_unlock_and_param_store;
  import sec_gate_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, boot_start;
  logic [1:0] bresp, rresp, rsp;
  mode_e mode;
  logic [7:0] neg_delta_volt, taper_window;
  logic [15:0] inhibit_temp_low, v;
  logic [2:0] m = 3'h0;
  int err_total = 0, tests_run = 0, boots = 0;
  sec_link_if link();
  sec_gate_device sec_gate_device_i (.aclk(aclk), .aresetn(aresetn), .link(link),
    .mode(mode), .boot_start(boot_start), .neg_delta_volt(neg_delta_volt),
    .inhibit_temp_low(inhibit_temp_low), .taper_window(taper_window));
  sec_gate_host sec_gate_host_i (.aclk(aclk), .aresetn(aresetn), .link(link),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
  sec_gate_assertions sec_gate_assertions_i (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(link.cmd_valid), .df_req(link.df_req), .df_we(link.df_we),
    .df_addr(link.df_addr), .df_wdata(link.df_wdata), .df_ack(link.df_ack),
    .df_err(link.df_err), .sealed_flag(link.sealed_flag),
    .full_access_state_flag(link.full_access_state_flag));
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (boot_start === 1'b1) boots++;
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd
  // Key words go out through CMD, so the bench does the byte swap
  function automatic logic [15:0] sw(input logic [15:0] k);
    return {k[7:0], k[15:8]};
  endfunction : sw
  task automatic cmd(input logic [15:0] k);
    wr(OFS_CMD, {16'h0000, k});
    repeat (4) @(posedge aclk);
  endtask : cmd
  task automatic keys(input logic [15:0] k0, k1);
    wr(OFS_CMD, {16'h0000, k0});
    cmd(k1);
  endtask : keys
  task automatic lvl(input mode_e e);
    `CHK("mode", e, mode);
    `CHK("sealed", e == MODE_SEALED, link.sealed_flag);
    `CHK("full_flag", e != MODE_FULL, link.full_access_state_flag);
  endtask : lvl
  // One parameter request; leaves the read data word in rdv
  task automatic df(input logic we, input logic [15:0] a, d, input logic e);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_DF_ADDR, {16'h0000, a});
    `CHK("irq_clr", 1'b0, irq);
    wr(OFS_DF_WDATA, {16'h0000, d});
    wr(OFS_DF_CTRL, we ? 32'h1 : 32'h2);
    repeat (4) @(posedge aclk);
    rd(OFS_IRQ_STAT);
    `CHK("df_err", e, rdv[1]);
    `CHK("df_done", 1'b1, rdv[0]);
    `CHK("irq", m[0] | (m[1] & e), irq);
    rd(OFS_DF_RDATA);
  endtask : df
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h17d5));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS);
    `CHK("status", 3'h3, rdv[2:0]);
    `CHK("neg", NEG_DELTA_RST, neg_delta_volt);
    `CHK("inh", INHIBIT_LOW_RST, inhibit_temp_low);
    `CHK("taper", TAPER_WIN_RST, taper_window);
    rd(8'h40);
    `CHK("unmapped", RESP_SLVERR, rsp);
    df(1'b0, ADDR_NEG_DELTA, 16'h0000, 1'b0);
    `CHK("neg_rd", {8'h00, NEG_DELTA_RST}, rdv[15:0]);
    df(1'b1, ADDR_TAPER_WIN, 16'h001E, 1'b1);
    `CHK("taper", TAPER_WIN_RST, taper_window);
    keys(sw(FULL_K0_RST), sw(FULL_K1_RST));
    lvl(MODE_SEALED);
    wr(OFS_CMD, {16'h0000, sw(UNSEAL_K0_RST)});
    keys(16'h0000, sw(UNSEAL_K1_RST));
    lvl(MODE_SEALED);
    keys(sw(UNSEAL_K0_RST), 16'h1234);
    keys(sw(UNSEAL_K0_RST), sw(UNSEAL_K1_RST));
    lvl(MODE_UNSEALED);
    m = 3'h3;
    wr(OFS_IRQ_MASK, {29'h0, m});
    df(1'b1, ADDR_UNSEAL_K0, 16'hBEEF, 1'b1);
    cmd(SUBCMD_BOOT);
    `CHK("boot", 0, boots);
    keys(sw(FULL_K0_RST), sw(FULL_K1_RST));
    lvl(MODE_FULL);
    rd(OFS_STATUS);
    `CHK("status_full", 3'h0, rdv[2:0]);
    rd(OFS_IRQ_STAT);
    `CHK("mode_irq", 1'b1, rdv[IRQ_MODE]);
    cmd(SUBCMD_BOOT);
    `CHK("boot", 1, boots);
    df(1'b1, ADDR_TAPER_WIN, 16'h003D, 1'b1);
    df(1'b1, ADDR_NEG_DELTA, 16'h0065, 1'b1);
    df(1'b1, ADDR_NEG_DELTA, 16'h0064, 1'b0);
    `CHK("neg", 8'h64, neg_delta_volt);
    df(1'b1, ADDR_INHIBIT_LOW, 16'hFE6F, 1'b1);
    df(1'b1, ADDR_INHIBIT_LOW, 16'h04B1, 1'b1);
    df(1'b1, ADDR_INHIBIT_LOW, 16'hFE70, 1'b0);
    `CHK("inh", 16'hFE70, inhibit_temp_low);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'h003C : 16'($urandom_range(60));
      df(1'b1, ADDR_TAPER_WIN, v, 1'b0);
      `CHK("taper", v[7:0], taper_window);
      v = (i == 0) ? 16'h04B0 : 16'($urandom_range(1600)) - 16'h0190;
      df(1'b1, ADDR_INHIBIT_LOW, v, 1'b0);
      df(1'b0, ADDR_INHIBIT_LOW, 16'h0000, 1'b0);
      `CHK("inh_rd", v, rdv[15:0]);
    end
    df(1'b1, ADDR_UNSEAL_K0, 16'hC0DE, 1'b0);
    df(1'b0, ADDR_UNSEAL_K0, 16'h0000, 1'b0);
    `CHK("key_rd", 16'hC0DE, rdv[15:0]);
    cmd(SUBCMD_SEAL);
    lvl(MODE_SEALED);
    df(1'b0, ADDR_UNSEAL_K0, 16'h0000, 1'b1);
    keys(sw(UNSEAL_K0_RST), sw(UNSEAL_K1_RST));
    lvl(MODE_SEALED);
    keys(sw(16'hC0DE), sw(UNSEAL_K1_RST));
    lvl(MODE_UNSEALED);
    m = 3'h0;
    wr(OFS_IRQ_MASK, {29'h0, m});
    df(1'b1, ADDR_TAPER_WIN, 16'h003D, 1'b1);
    give_verdict();
  end
endmodule : test_security_key_unlock_and_param_store
